/* design/tsc_bank.sv */
// Purpose: Transmit subaddress control words with host access and terminal updates
// Assumes: Wishbone classic slave, ack one cycle after the strobe, dropped the next
// Notes:   Terminal events are taken every cycle; host writes merge with events
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module tsc_bank (
  input  wire logic              SYS_CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire tsc_pkg::tsc_evt_t EVT_I,
  output tsc_pkg::tsc_resp_t     RESP_O,
  output logic                   MSG_IRQ_O,
  output logic                   IRQ_INDEX_ZERO_O,
  output logic                   IRQ_ACCESSED_O,
  output logic                   SOFT_RST_O
);
  import tsc_pkg::*;

  // Word 0 is never used; keeping it lets the subaddress index the array directly
  logic [15:0] cw_ff [SA_MAX+1];
  logic [15:0] nxt_cw [SA_MAX+1];
  logic [4:0]  cfg_ff, nxt_cfg;
  logic        ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic        irq_ff, nxt_irq;
  logic        izero_ff, nxt_izero;
  logic        acc_irq_ff, nxt_acc_irq;
  logic        soft_rst_ff, nxt_soft_rst;
  tsc_resp_t   resp_ff, nxt_resp;

  logic        req, wr, rd;
  logic [5:0]  widx;
  logic        sa_ok, evt_hit;
  logic [15:0] wdata;

  assign req   = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr    = req && WB_WE_I;
  assign rd    = req && !WB_WE_I;
  assign widx  = WB_ADR_I[7:2];
  assign wdata = {WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00, WB_SEL_I[0] ? WB_DAT_I[7:0] : 8'h00};
  assign sa_ok = (int'(EVT_I.subaddr) >= SA_MIN) && (int'(EVT_I.subaddr) <= SA_MAX);
  assign evt_hit = EVT_I.valid && EVT_I.tx && sa_ok;

  // Per-word next-state: host access, terminal events, soft reset
  for (genvar g = 0; g <= SA_MAX; g++) begin : g_word
    logic [15:0] wmask;
    logic        whit, rhit, ehit;
    assign whit = wr && (widx == 6'(g)) && (g >= SA_MIN) && (WB_SEL_I[1:0] == 2'b11);
    assign rhit = rd && (widx == 6'(g)) && (g >= SA_MIN);
    assign ehit = evt_hit && (EVT_I.subaddr == 5'(g));
    // Bits 8-11 and 13 absent from both masks
    assign wmask = MASK_ANYTIME | (cfg_ff[CFG_EXEC] ? 16'h0000 : MASK_IDLEONLY);
    always_comb begin
      nxt_cw[g] = cw_ff[g];
      if (whit) begin
        nxt_cw[g] = (cw_ff[g] & ~wmask) | (wdata & wmask);
      end
      if (rhit) begin
        nxt_cw[g][BIT_ACCESSED] = 1'b0;
      end
      // Soft reset beats events because the event block is skipped while it is set
      if (soft_rst_ff) begin
        nxt_cw[g] = nxt_cw[g] & ~MASK_SOFT_RST;
      end
      // Event sets come after the read clear, so a same-cycle set wins
      if (ehit && cfg_ff[CFG_EXEC] && !soft_rst_ff) begin
        if (EVT_I.start && EVT_I.broadcast) begin
          nxt_cw[g][BIT_BROADCAST] = 1'b1;
        end
        if (!EVT_I.start) begin
          nxt_cw[g][BIT_ACCESSED] = 1'b1;
          if (cw_ff[g][2:0] == MODE_PINGPONG && !EVT_I.error && !EVT_I.illegal
              && !resp_ff.busy) begin
            nxt_cw[g][BIT_PINGPONG] = ~cw_ff[g][BIT_PINGPONG];
          end
        end
      end
      nxt_cw[g][BIT_UNUSED] = 1'b0;
    end
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
        cw_ff[g] <= CW_RESET;
      end else begin
        cw_ff[g] <= nxt_cw[g];
      end
    end

    chk_word_unused: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      cw_ff[g][BIT_UNUSED] == 1'b0)
      else $error("unused bit set in a control word");

    chk_word_rd_clear: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
      rhit && !ehit |=> !cw_ff[g][BIT_ACCESSED])
      else $error("read left the accessed bit set");
  end

  // Bus, config, response and interrupt logic
  always_comb begin
    logic [15:0] ecw;
    ecw       = cw_ff[EVT_I.subaddr];
    nxt_ack   = req;
    nxt_dat   = dat_ff;
    nxt_cfg   = cfg_ff;
    nxt_soft_rst = 1'b0;
    nxt_resp  = resp_ff;
    nxt_izero = 1'b0;
    nxt_acc_irq = 1'b0;
    nxt_irq   = 1'b0;
    if (rd) begin
      if (WB_ADR_I == ADDR_CONFIG) begin
        nxt_dat = {27'h0, cfg_ff};
      end else if (WB_ADR_I == ADDR_STATUS) begin
        nxt_dat = {26'h0, resp_ff};
      end else if ((widx >= 6'(SA_MIN)) && (widx <= 6'(SA_MAX))) begin
        nxt_dat = {16'h0, cw_ff[widx[4:0]]};
      end else begin
        nxt_dat = 32'h0;
      end
    end
    if (wr && WB_ADR_I == ADDR_CONFIG && WB_SEL_I[0]) begin
      // Soft reset bit is a strobe and is never stored
      nxt_cfg      = {1'b0, WB_DAT_I[3:0]};
      nxt_soft_rst = WB_DAT_I[CFG_SOFT_RST];
    end
    if (evt_hit && EVT_I.start) begin
      nxt_resp.busy      = ecw[BIT_BUSY] || cfg_ff[CFG_GBUSY];
      nxt_resp.send_data = !nxt_resp.busy;
      nxt_resp.use_ptr_b = ecw[BIT_PINGPONG];
      nxt_resp.mode      = ecw[2:0];
    end
    // Interrupts fire only at completion, once command processing is over
    if (evt_hit && !EVT_I.start && cfg_ff[CFG_EXEC]) begin
      nxt_izero = ecw[BIT_IZERO_EN] && cfg_ff[CFG_IZERO_EN] &&
                  ((ecw[2:0] == MODE_INDEXED && EVT_I.index_to_zero) ||
                   (ecw[2:1] == 2'b01 && EVT_I.circ_done));
      nxt_acc_irq = ecw[BIT_ACC_EN] && cfg_ff[CFG_ACC_EN];
      nxt_irq   = nxt_izero || nxt_acc_irq;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_ff   <= 1'b0;
      dat_ff   <= 32'h0;
      cfg_ff   <= 5'h00;
      soft_rst_ff <= 1'b0;
      resp_ff  <= '0;
      izero_ff <= 1'b0;
      acc_irq_ff <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      ack_ff   <= nxt_ack;
      dat_ff   <= nxt_dat;
      cfg_ff   <= nxt_cfg;
      soft_rst_ff <= nxt_soft_rst;
      resp_ff  <= nxt_resp;
      izero_ff <= nxt_izero;
      acc_irq_ff <= nxt_acc_irq;
      irq_ff   <= nxt_irq;
    end
  end

  assign WB_ACK_O         = ack_ff;
  assign WB_DAT_O         = dat_ff;
  assign RESP_O           = resp_ff;
  assign MSG_IRQ_O        = irq_ff;
  assign IRQ_INDEX_ZERO_O = izero_ff;
  assign IRQ_ACCESSED_O   = acc_irq_ff;
  assign SOFT_RST_O       = soft_rst_ff;

  // Word checks use fixed subaddresses that the scenarios drive, except subaddress 7, which no scenario touches

  chk_read_clears: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    rd && widx == 6'd5 |=> !cw_ff[5][BIT_ACCESSED] || $past(evt_hit))
    else $error("accessed bit survived a read");
  chk_soft_clears: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    soft_rst_ff |=> (cw_ff[3] & MASK_SOFT_RST) == 16'h0)
    else $error("soft reset left status bits");
  chk_soft_keeps: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    soft_rst_ff && !wr |=> (cw_ff[3] & ~MASK_SOFT_RST) == ($past(cw_ff[3]) & ~MASK_SOFT_RST))
    else $error("soft reset disturbed config bits");
  chk_unused_zero: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    cw_ff[7][BIT_UNUSED] == 1'b0)
    else $error("unused bit set");
  chk_status_ro: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr && widx == 6'd2 && !evt_hit && !soft_rst_ff |=> cw_ff[2][11:8] == $past(cw_ff[2][11:8]))
    else $error("host changed status bits");
  chk_exec_lock: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    cfg_ff[CFG_EXEC] |=> (cw_ff[4] & MASK_IDLEONLY) == ($past(cw_ff[4]) & MASK_IDLEONLY))
    else $error("locked bits changed during execution");
  chk_busy_nodata: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    resp_ff.busy |-> !resp_ff.send_data)
    else $error("data sent while busy");
  chk_irq_cause: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    MSG_IRQ_O |-> $past(evt_hit && !EVT_I.start))
    else $error("interrupt without completion");
  chk_complete_sets: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && !EVT_I.start && EVT_I.subaddr == 5'd6 && cfg_ff[CFG_EXEC] && !soft_rst_ff
    |=> cw_ff[6][BIT_ACCESSED])
    else $error("completion did not set accessed bit");
  chk_ack_one: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

  // Receive commands must leave the transmit words alone
  chk_rx_ignored: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    EVT_I.valid && !EVT_I.tx && !wr && !rd && !soft_rst_ff
    |=> cw_ff[4] == $past(cw_ff[4]))
    else $error("receive command changed a transmit word");

  chk_sa_range: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    EVT_I.valid && (EVT_I.subaddr == 5'd0 || EVT_I.subaddr == 5'd31) |=> !MSG_IRQ_O)
    else $error("out-of-range subaddress raised an interrupt");

  // Events leave the words unchanged while execution is off
  chk_exec_off_frozen: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !cfg_ff[CFG_EXEC] && !wr && !rd && !soft_rst_ff
    |=> cw_ff[2][11:8] == $past(cw_ff[2][11:8]))
    else $error("status bits moved with execution off");

  chk_anytime_write: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr && WB_ADR_I == 8'h04 && WB_SEL_I[1:0] == 2'b11
    |=> (cw_ff[1] & MASK_ANYTIME) == ($past(WB_DAT_I[15:0]) & MASK_ANYTIME))
    else $error("anytime bits not written");

  chk_idle_write: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    wr && WB_ADR_I == 8'h04 && WB_SEL_I[1:0] == 2'b11 && !cfg_ff[CFG_EXEC]
    |=> (cw_ff[1] & MASK_IDLEONLY) == ($past(WB_DAT_I[15:0]) & MASK_IDLEONLY))
    else $error("idle-only bits not written while stopped");

  // Ping-pong pointer on subaddress 2, which the scenarios run in mode 1
  chk_pp_toggle: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && !EVT_I.start && EVT_I.subaddr == 5'd2 && cfg_ff[CFG_EXEC] && !soft_rst_ff
    && cw_ff[2][2:0] == MODE_PINGPONG && !EVT_I.error && !EVT_I.illegal && !resp_ff.busy
    |=> cw_ff[2][BIT_PINGPONG] != $past(cw_ff[2][BIT_PINGPONG]))
    else $error("pointer did not toggle after a clean message");

  chk_pp_hold_err: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && EVT_I.subaddr == 5'd2 && (EVT_I.error || EVT_I.illegal) && !soft_rst_ff
    |=> cw_ff[2][BIT_PINGPONG] == $past(cw_ff[2][BIT_PINGPONG]))
    else $error("pointer toggled after a faulty message");

  chk_busy_no_toggle: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && !EVT_I.start && EVT_I.subaddr == 5'd2 && resp_ff.busy && !soft_rst_ff
    |=> cw_ff[2][BIT_PINGPONG] == $past(cw_ff[2][BIT_PINGPONG]))
    else $error("pointer toggled after a busy reply");

  chk_broadcast_received_sets: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && EVT_I.start && EVT_I.broadcast && EVT_I.subaddr == 5'd5
    && cfg_ff[CFG_EXEC] && !soft_rst_ff
    |=> cw_ff[5][BIT_BROADCAST])
    else $error("broadcast bit not set");

  // Busy reply is latched at the start event
  chk_busy_resp: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && EVT_I.start && EVT_I.subaddr == 5'd3 && cw_ff[3][BIT_BUSY]
    |=> resp_ff.busy)
    else $error("subaddress busy bit ignored");

  chk_global_busy: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && EVT_I.start && cfg_ff[CFG_GBUSY] |=> resp_ff.busy)
    else $error("global busy ignored");

  chk_not_busy: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && EVT_I.start && EVT_I.subaddr == 5'd2 && !cfg_ff[CFG_GBUSY]
    && !cw_ff[2][BIT_BUSY]
    |=> !resp_ff.busy && resp_ff.send_data)
    else $error("busy reply without a cause");

  chk_mode_follow: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && EVT_I.start && EVT_I.subaddr == 5'd4
    |=> resp_ff.mode == $past(cw_ff[4][2:0]))
    else $error("buffer mode not taken from the word");

  // Interrupt pulses and their enables
  chk_acc_irq: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && !EVT_I.start && EVT_I.subaddr == 5'd4 && cfg_ff[CFG_EXEC]
    && cw_ff[4][BIT_ACC_EN] && cfg_ff[CFG_ACC_EN]
    |=> IRQ_ACCESSED_O && MSG_IRQ_O)
    else $error("accessed interrupt missing");

  chk_izero_indexed: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && !EVT_I.start && EVT_I.subaddr == 5'd4 && cfg_ff[CFG_EXEC]
    && cw_ff[4][BIT_IZERO_EN] && cfg_ff[CFG_IZERO_EN]
    && cw_ff[4][2:0] == MODE_INDEXED && EVT_I.index_to_zero
    |=> IRQ_INDEX_ZERO_O && MSG_IRQ_O)
    else $error("index-zero interrupt missing in indexed mode");

  chk_izero_circ: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    evt_hit && !EVT_I.start && EVT_I.subaddr == 5'd6 && cfg_ff[CFG_EXEC]
    && cw_ff[6][BIT_IZERO_EN] && cfg_ff[CFG_IZERO_EN]
    && cw_ff[6][2:1] == 2'b01 && EVT_I.circ_done
    |=> IRQ_INDEX_ZERO_O && MSG_IRQ_O)
    else $error("index-zero interrupt missing in circular mode");

  chk_izero_needs_en: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    IRQ_INDEX_ZERO_O |-> $past(cfg_ff[CFG_IZERO_EN]))
    else $error("index-zero interrupt while disabled");

  chk_acc_needs_en: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    IRQ_ACCESSED_O |-> $past(cfg_ff[CFG_ACC_EN]))
    else $error("accessed interrupt while disabled");

  chk_msg_pin_or: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    MSG_IRQ_O == (IRQ_INDEX_ZERO_O || IRQ_ACCESSED_O))
    else $error("message pin does not follow its causes");

  // The master reset check runs without a disable so it sees the release itself
  chk_master_reset: assert property (@(posedge SYS_CLK_I)
    $fell(SYS_RST_I) |-> cw_ff[4] == CW_RESET && !WB_ACK_O && cfg_ff == 5'h00)
    else $error("state not cleared by master reset");

  chk_soft_pulse: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    soft_rst_ff |=> !soft_rst_ff)
    else $error("soft reset stretched");

  chk_read_data: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    rd && widx == 6'd1 |=> WB_DAT_O[15:0] == $past(cw_ff[1]))
    else $error("read data differs from the word");

  cov_busy:  cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) resp_ff.busy);
  cov_irq:   cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) IRQ_INDEX_ZERO_O);
  cov_write: cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) wr && widx == 6'd1);
  cov_soft:  cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I) soft_rst_ff);
  cov_flip:  cover property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    cw_ff[2][BIT_PINGPONG] && !$past(cw_ff[2][BIT_PINGPONG]));
endmodule // tsc_bank

/* design/tsc_pkg.sv */
// Purpose: Constants and types for the transmit subaddress control word bank
// Assumes: One control word per transmit subaddress 1..30, reached over classic Wishbone
// Notes:   Message-processing events arrive as one-cycle pulses with their subaddress
//
// What this block does
// - Word applies only to valid transmit commands with subaddress 1 through 30.
// - Host writes never change bits 8 through 11.
// - While execution is on, the terminal updates bits 9 through 11.
// - Bits 0-2 and 4-7 are writable only while execution is off.
// - Bits 3, 12, 14 and 15 are writable at any time.
// - Master reset clears the whole word to zero.
// - Software reset clears only accessed, ping-pong pointer and broadcast bits.
// - Any host read of the word clears the accessed bit.
// - Index-zero interrupt in indexed mode when index goes from one to zero.
// - Index-zero interrupt in circular mode when preset message count completes.
// - Enabled index-zero interrupt pends, raises message pin, logs, at command end; here one-cycle pulses on IRQ_INDEX_ZERO_O and MSG_IRQ_O, no log.
// - Accessed interrupt for every valid transmit command when bit 14 enabled.
// - Enabled accessed interrupt pends, raises message pin, logs at completion; here one-cycle pulses on IRQ_ACCESSED_O and MSG_IRQ_O, no log.
// - Bit 12 set makes this subaddress answer with busy status.
// - Busy applies when per-subaddress bit or global busy is active.
// - While busy, send no data and do not toggle ping-pong pointer.
// - Accessed bit 11 is set when message processing completes.
// - In ping-pong mode bit 10 inverts after error-free messages only.
// - Bit 9 is set when a broadcast transmit command arrives.
package tsc_pkg;
  localparam int          SA_MIN        = 1;
  localparam int          SA_MAX        = 30;
  localparam int          BIT_IZERO_EN  = 15;
  localparam int          BIT_ACC_EN    = 14;
  localparam int          BIT_UNUSED    = 13;
  localparam int          BIT_BUSY      = 12;
  localparam int          BIT_ACCESSED  = 11;
  localparam int          BIT_PINGPONG  = 10;
  localparam int          BIT_BROADCAST = 9;
  localparam logic [15:0] CW_RESET      = 16'h0000;
  localparam logic [15:0] MASK_ANYTIME  = 16'hd008;
  localparam logic [15:0] MASK_IDLEONLY = 16'h00f7;
  localparam logic [15:0] MASK_SOFT_RST = 16'h0e00;
  localparam logic [2:0]  MODE_INDEXED  = 3'h0;
  localparam logic [2:0]  MODE_PINGPONG = 3'h1;
  // Word offset 0 is the config register; control words sit at word index = subaddress
  localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h7c;
  localparam int          CFG_EXEC      = 0;
  localparam int          CFG_GBUSY     = 1;
  localparam int          CFG_IZERO_EN  = 2;
  localparam int          CFG_ACC_EN    = 3;
  localparam int          CFG_SOFT_RST  = 4;

  typedef struct packed {
    logic       valid;     // One-cycle pulse
    logic       start;     // 1: command accepted, 0: completion
    logic       tx;
    logic       broadcast;
    logic       error;
    logic       illegal;
    logic [4:0] subaddr;
    logic       index_to_zero;
    logic       circ_done;
  } tsc_evt_t;

  typedef struct packed {
    logic busy;
    logic send_data;
    logic use_ptr_b;
    logic [2:0] mode;
  } tsc_resp_t;
endpackage

/* bench/tsc_term_model.sv */
// Purpose: Terminal stand-in issuing start and completion events
// Assumes: One message at a time; go is ignored while one is in flight
// Notes:   Idle fields carry inverted junk so nothing leans on stale values
`timescale 1ns/1ps
module tsc_term_model
  import tsc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire tsc_evt_t   cmd_i,
  input  wire logic [3:0] gap_i,
  output tsc_evt_t        evt_o,
  output logic            done_o
);
  logic [3:0] cnt_ff;
  logic       run_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_o <= '0;
      done_o <= 1'b0;
      run_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else begin
      evt_o <= ~cmd_i;
      evt_o.valid <= 1'b0;
      done_o <= 1'b0;
      if (go_i && !run_ff) begin
        evt_o <= cmd_i;
        evt_o.valid <= 1'b1;
        evt_o.start <= 1'b1;
        run_ff <= 1'b1;
        cnt_ff <= gap_i;
      end else if (run_ff && cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else if (run_ff) begin
        evt_o <= cmd_i;
        evt_o.valid <= 1'b1;
        evt_o.start <= 1'b0;
        run_ff <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule // tsc_term_model

/* bench/tsc_bank_tb.sv */
// Purpose: Self-checking bench for the transmit control word bank
// Assumes: Wishbone ack comes after the strobe; events from the terminal model
// Notes:   Pulses are counted so a doubled or missing pulse shows up
`timescale 1ns/1ps
module tsc_bank_tb;
  import tsc_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, go, done;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  gap, pulse, sel;
  tsc_evt_t    cmd, evt;
  tsc_resp_t   resp;
  int          n_fail, checked;
  int          cnt[4], base[4];
  tsc_bank dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .EVT_I(evt), .RESP_O(resp), .MSG_IRQ_O(pulse[0]),
    .IRQ_INDEX_ZERO_O(pulse[1]), .IRQ_ACCESSED_O(pulse[2]), .SOFT_RST_O(pulse[3]));
  tsc_term_model term (.clk_i(clk), .rst_i(rst), .go_i(go), .cmd_i(cmd), .gap_i(gap),
    .evt_o(evt), .done_o(done));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) for (int i = 0; i < 4; i++) cnt[i] <= cnt[i] + int'(pulse[i]);
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 20) chk("wb_ack", 32'h1, 32'h0);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    wb(1'b0, a, 16'h0000);
    chk(nm, {16'h0000, exp}, {16'h0000, rdat[15:0]});
  endtask
  task msg(input logic [4:0] sa, input logic tx, bc, er, itz, circ, input logic [3:0] g);
    int i;
    base = cnt;
    @(posedge clk);
    cmd <= tsc_evt_t'({2'b00, tx, bc, er, bc, sa, itz, circ});
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (done !== 1'b1 && i < 30);
    repeat (3) @(posedge clk);
  endtask
  task pulses(input logic [3:0] exp);
    for (int i = 0; i < 4; i++) chk($sformatf("pulse%0d", i), 32'(exp[i]), cnt[i] - base[i]);
  endtask
  task t_idle;
    rd(8'h14, 16'h0000, "sa5_reset");
    rd(8'hf0, 16'h0000, "unmapped");
    wb(1'b1, 8'h04, 16'hffff);
    rd(8'h04, 16'hd0ff, "sa1_idle_wr");
    wb(1'b1, 8'h08, 16'h0001);
    wb(1'b1, 8'h0c, 16'h1001);
    wb(1'b1, 8'h10, 16'hc000);
    wb(1'b1, 8'h18, 16'h8002);
    wb(1'b1, 8'h00, 16'h000d);
    wb(1'b1, 8'h04, 16'h0000);
    rd(8'h04, 16'h00f7, "sa1_exec_wr");
    sel <= 4'h1;
    wb(1'b1, 8'h04, 16'hffff);
    sel <= 4'hf;
    rd(8'h04, 16'h00f7, "sa1_half_sel");
  endtask
  task t_pingpong;
    msg(5'd2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    chk("resp_a", 32'h11, {26'h0, resp});
    rd(8'h08, 16'h0c01, "sa2_done");
    rd(8'h08, 16'h0401, "sa2_reread");
    msg(5'd2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h6);
    chk("resp_b", 32'h19, {26'h0, resp});
    rd(8'h08, 16'h0c01, "sa2_err");
  endtask
  task t_busy;
    msg(5'd3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2);
    chk("resp_sa_busy", 32'h21, {26'h0, resp});
    rd(8'h0c, 16'h1801, "sa3_busy");
    wb(1'b1, 8'h00, 16'h000f);
    msg(5'd2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    chk("resp_gbusy", 32'h29, {26'h0, resp});
    rd(8'h08, 16'h0c01, "sa2_gbusy");
    wb(1'b1, 8'h00, 16'h000d);
  endtask
  task t_irq;
    msg(5'd5, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
    rd(8'h14, 16'h0a00, "sa5_broadcast_received");
    msg(5'd4, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h1);
    pulses(4'b0111);
    chk("resp_indexed", 32'h10, {26'h0, resp});
    rd(8'h10, 16'hc800, "sa4_acc");
    msg(5'd6, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
    pulses(4'b0011);
    msg(5'd4, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
    pulses(4'b0000);
    rd(8'h10, 16'hc000, "sa4_rx");
  endtask
  task t_resets;
    base = cnt;
    wb(1'b1, 8'h00, 16'h001d);
    repeat (3) @(posedge clk);
    pulses(4'b1000);
    rd(8'h08, 16'h0001, "sa2_soft_rst");
    rd(8'h14, 16'h0000, "sa5_soft_rst");
    rd(8'h18, 16'h8002, "sa6_soft_rst");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h10, 16'h0000, "sa4_master_rst");
  endtask
  task print_verdict;
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {cyc, stb, we, go, adr, wdat, gap} = '0;
    cmd = '0;
    sel = 4'hf;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_idle;
    t_pingpong;
    t_busy;
    t_irq;
    t_resets;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // tsc_bank_tb
